// ==== core/tmr16_core.v ====
`timescale 1ns/10ps
`include "tmr16_regs.vh"

module tmr16_core (
	clk,
	srst,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	capture_input_pin,
	analog_comp_out,
	external_count_pin,
	global_irq_en,
	vector_ack,
	capture_irq,
	compare_a_irq,
	compare_b_irq,
	overflow_irq,
	compare_output_a_pin,
	compare_output_a_oe,
	compare_output_b_pin,
	compare_output_b_oe
);
	input wire clk;
	input wire srst;
	input wire [7:0] reg_addr;
	input wire [7:0] reg_wdata;
	input wire reg_wr;
	input wire reg_rd;
	output reg [7:0] reg_rdata;
	input wire capture_input_pin;
	input wire analog_comp_out;
	input wire external_count_pin;
	input wire global_irq_en;
	input wire [3:0] vector_ack;
	output reg capture_irq;
	output reg compare_a_irq;
	output reg compare_b_irq;
	output reg overflow_irq;
	output reg compare_output_a_pin;
	output reg compare_output_a_oe;
	output reg compare_output_b_pin;
	output reg compare_output_b_oe;

	reg [7:0] ctrl_a_r;
	reg capture_noise_filter_en;
	reg capture_edge_sel;
	reg [1:0] wave_hi_r;
	reg [2:0] clock_source_sel;
	reg [15:0] counter_register;
	reg [15:0] cmpa_buf_r;
	reg [15:0] cmpb_buf_r;
	reg [15:0] compare_a_register;
	reg [15:0] compare_b_register;
	reg [15:0] capture_register;
	reg [7:0] high_latch_r;
	reg [9:0] presc_r;
	reg count_up_r;
	reg match_block_r;
	reg capture_irq_en;
	reg compare_a_irq_en;
	reg compare_b_irq_en;
	reg overflow_irq_en;
	reg capture_flag;
	reg compare_a_flag;
	reg compare_b_flag;
	reg overflow_flag;

	wire [3:0] waveform_mode_sel;
	wire [1:0] act_a;
	wire [1:0] act_b;
	wire capt_lvl;
	wire capt_rise;
	wire capt_fall;
	wire ext_rise;
	wire ext_fall;
	wire wr_cnt;
	wire capt_top;
	wire phase_mode;
	wire fast_mode;
	wire nonpwm_mode;
	wire buf_at_bottom;
	wire toggle_a_ok;
	wire at_top;
	wire at_bottom;
	wire match_a;
	wire match_b;
	wire capt_evt;
	wire ovf_evt;
	wire force_a;
	wire force_b;
	wire [3:0] flag_wr_clr;

	reg tick;
	reg [15:0] top_val;

	assign waveform_mode_sel = {wave_hi_r, ctrl_a_r[1:0]};
	assign act_a = ctrl_a_r[`TMR16_ACT_A_HI:`TMR16_ACT_A_LO];
	assign act_b = ctrl_a_r[`TMR16_ACT_B_HI:`TMR16_ACT_B_LO];

	// Capture path, filter applies to whichever source is selected
	tmr16_edge_filter #(
		.SAMPLES(`TMR16_FILTER_SAMPLES)
	) u_capt_filter (
		.clk(clk),
		.srst(srst),
		.filter_en(capture_noise_filter_en),
		.sample_in(ctrl_a_r[`TMR16_CAPT_SRC_BIT] ? analog_comp_out :
			capture_input_pin),
		.level_out(capt_lvl),
		.rise_out(capt_rise),
		.fall_out(capt_fall)
	);

	// Pin level is read regardless of its port direction
	tmr16_edge_filter #(
		.SAMPLES(`TMR16_FILTER_SAMPLES)
	) u_ext_edge (
		.clk(clk),
		.srst(srst),
		.filter_en(1'b0),
		.sample_in(external_count_pin),
		.level_out(),
		.rise_out(ext_rise),
		.fall_out(ext_fall)
	);

	// Mode decode
	assign capt_top = (waveform_mode_sel == 4'h8) ||
		(waveform_mode_sel == 4'ha) || (waveform_mode_sel == 4'hc) ||
		(waveform_mode_sel == 4'he);
	assign phase_mode = (waveform_mode_sel >= 4'h1 &&
		waveform_mode_sel <= 4'h3) || (waveform_mode_sel >= 4'h8 &&
		waveform_mode_sel <= 4'hb);
	assign fast_mode = (waveform_mode_sel >= 4'h5 &&
		waveform_mode_sel <= 4'h7) || (waveform_mode_sel >= 4'he);
	assign nonpwm_mode = ~phase_mode & ~fast_mode;
	assign buf_at_bottom = (waveform_mode_sel == 4'h8) ||
		(waveform_mode_sel == 4'h9);
	assign toggle_a_ok = (waveform_mode_sel >= 4'he) ||
		(waveform_mode_sel >= 4'h8 && waveform_mode_sel <= 4'hb);

	always @* begin
		case (waveform_mode_sel)
		4'h1, 4'h5: top_val = `TMR16_TOP8;
		4'h2, 4'h6: top_val = `TMR16_TOP9;
		4'h3, 4'h7: top_val = `TMR16_TOP10;
		4'h4, 4'h9, 4'hb, 4'hf: top_val = compare_a_register;
		4'h8, 4'ha, 4'hc, 4'he: top_val = capture_register;
		default: top_val = `TMR16_MAX;
		endcase
	end

	// Free-running prescaler shared by all divided selections
	always @* begin
		case (clock_source_sel)
		`TMR16_CS_DIV1: tick = 1'b1;
		`TMR16_CS_DIV8: tick = &presc_r[2:0];
		`TMR16_CS_DIV64: tick = &presc_r[5:0];
		`TMR16_CS_DIV256: tick = &presc_r[7:0];
		`TMR16_CS_DIV1024: tick = &presc_r;
		`TMR16_CS_EXT_FALL: tick = ext_fall;
		`TMR16_CS_EXT_RISE: tick = ext_rise;
		default: tick = 1'b0;
		endcase
	end

	assign wr_cnt = reg_wr && reg_addr == `TMR16_CNT_L;
	assign at_top = counter_register == top_val;
	assign at_bottom = counter_register == `TMR16_RESET_WORD;
	assign match_a = tick & ~match_block_r &
		(counter_register == compare_a_register);
	assign match_b = tick & ~match_block_r &
		(counter_register == compare_b_register);
	assign capt_evt = ~capt_top & (capture_edge_sel ? capt_rise :
		capt_fall);
	assign ovf_evt = tick & (phase_mode ? (at_bottom & ~count_up_r) :
		fast_mode ? at_top :
		(counter_register == `TMR16_MAX));
	assign force_a = reg_wr && reg_addr == `TMR16_CTRL_C && nonpwm_mode &&
		reg_wdata[`TMR16_FORCE_A_BIT];
	assign force_b = reg_wr && reg_addr == `TMR16_CTRL_C && nonpwm_mode &&
		reg_wdata[`TMR16_FORCE_B_BIT];
	assign flag_wr_clr = (reg_wr && reg_addr == `TMR16_IRQ_FLAGS) ?
		{reg_wdata[`TMR16_CAPT_BIT], reg_wdata[`TMR16_CMPB_BIT],
		reg_wdata[`TMR16_CMPA_BIT], reg_wdata[`TMR16_OVF_BIT]} : 4'h0;

	// Next level of a waveform output; a TOP action overrides a match
	function wave_next;
		input cur;
		input [1:0] act;
		input hit;
		input top_hit;
		input tog_ok;
		input fast;
		input phase;
		input up;
		reg val;
		begin
			val = cur;
			if (hit && act == 2'h1 && (tog_ok || (!fast && !phase)))
				val = ~cur;
			else if (hit && act[1])
				val = (fast || (phase && up)) ? ~act[0] : act[0];
			if (fast && top_hit && act[1])
				val = act[0];
			wave_next = val;
		end
	endfunction

	always @(posedge clk) begin
		if (srst) begin
			presc_r <= 10'h000;
			counter_register <= `TMR16_RESET_WORD;
			count_up_r <= 1'b1;
			match_block_r <= 1'b0;
			compare_a_register <= `TMR16_RESET_WORD;
			compare_b_register <= `TMR16_RESET_WORD;
		end else begin
			presc_r <= presc_r + 10'h001;
			if (wr_cnt)
				match_block_r <= 1'b1;
			else if (tick)
				match_block_r <= 1'b0;
			// CPU write outranks counting
			if (wr_cnt) begin
				counter_register <= {high_latch_r, reg_wdata};
			end else if (tick) begin
				if (!phase_mode) begin
					if (at_top)
						counter_register <= `TMR16_RESET_WORD;
					else
						counter_register <= counter_register + 16'h0001;
				end else if (count_up_r) begin
					if (at_top) begin
						count_up_r <= 1'b0;
						counter_register <= counter_register - 16'h0001;
					end else begin
						counter_register <= counter_register + 16'h0001;
					end
				end else begin
					if (at_bottom) begin
						count_up_r <= 1'b1;
						counter_register <= counter_register + 16'h0001;
					end else begin
						counter_register <= counter_register - 16'h0001;
					end
				end
			end
			if (!phase_mode)
				count_up_r <= 1'b1;
			// Buffered compare values reach the comparator at TOP or BOTTOM
			// in PWM modes, so a late write cannot cut a pulse short
			if (nonpwm_mode || (tick && (buf_at_bottom ? at_bottom :
				at_top))) begin
				compare_a_register <= cmpa_buf_r;
				compare_b_register <= cmpb_buf_r;
			end
		end
	end

	// Register writes, shared high latch and flags
	always @(posedge clk) begin
		if (srst) begin
			ctrl_a_r <= `TMR16_RESET_BYTE;
			capture_noise_filter_en <= 1'b0;
			capture_edge_sel <= 1'b0;
			wave_hi_r <= 2'h0;
			clock_source_sel <= `TMR16_CS_STOP;
			cmpa_buf_r <= `TMR16_RESET_WORD;
			cmpb_buf_r <= `TMR16_RESET_WORD;
			capture_register <= `TMR16_RESET_WORD;
			high_latch_r <= `TMR16_RESET_BYTE;
			capture_irq_en <= 1'b0;
			compare_a_irq_en <= 1'b0;
			compare_b_irq_en <= 1'b0;
			overflow_irq_en <= 1'b0;
			capture_flag <= 1'b0;
			compare_a_flag <= 1'b0;
			compare_b_flag <= 1'b0;
			overflow_flag <= 1'b0;
			reg_rdata <= `TMR16_RESET_BYTE;
		end else begin
			if (reg_wr) begin
				case (reg_addr)
				`TMR16_CTRL_A: ctrl_a_r <= reg_wdata;
				`TMR16_CTRL_B: begin
					capture_noise_filter_en <= reg_wdata[`TMR16_NOISE_BIT];
					capture_edge_sel <= reg_wdata[`TMR16_EDGE_BIT];
					wave_hi_r <=
						reg_wdata[`TMR16_WAVE_HI_HI:`TMR16_WAVE_HI_LO];
					clock_source_sel <=
						reg_wdata[`TMR16_CLKSEL_HI:`TMR16_CLKSEL_LO];
				end
				`TMR16_CNT_H, `TMR16_CMPA_H, `TMR16_CMPB_H, `TMR16_CAPT_H:
					high_latch_r <= reg_wdata;
				`TMR16_CMPA_L:
					cmpa_buf_r <= {high_latch_r, reg_wdata};
				`TMR16_CMPB_L:
					cmpb_buf_r <= {high_latch_r, reg_wdata};
				`TMR16_IRQ_MASK: begin
					capture_irq_en <= reg_wdata[`TMR16_CAPT_BIT];
					compare_b_irq_en <= reg_wdata[`TMR16_CMPB_BIT];
					compare_a_irq_en <= reg_wdata[`TMR16_CMPA_BIT];
					overflow_irq_en <= reg_wdata[`TMR16_OVF_BIT];
				end
				default: ;
				endcase
			end
			if (reg_rd) begin
				case (reg_addr)
				`TMR16_CNT_L: high_latch_r <= counter_register[15:8];
				`TMR16_CMPA_L: high_latch_r <= cmpa_buf_r[15:8];
				`TMR16_CMPB_L: high_latch_r <= cmpb_buf_r[15:8];
				`TMR16_CAPT_L: high_latch_r <= capture_register[15:8];
				default: ;
				endcase
			end
			// Capture update; a pin event outranks a CPU write
			if (capt_evt)
				capture_register <= counter_register;
			else if (reg_wr && reg_addr == `TMR16_CAPT_L)
				capture_register <= {high_latch_r, reg_wdata};
			// Hardware set wins over any clear
			capture_flag <= (capt_evt | (capt_top & tick & at_top)) |
				(capture_flag & ~flag_wr_clr[3] & ~vector_ack[3]);
			compare_b_flag <= match_b |
				(compare_b_flag & ~flag_wr_clr[2] & ~vector_ack[2]);
			compare_a_flag <= match_a |
				(compare_a_flag & ~flag_wr_clr[1] & ~vector_ack[1]);
			overflow_flag <= ovf_evt |
				(overflow_flag & ~flag_wr_clr[0] & ~vector_ack[0]);
			reg_rdata <= `TMR16_RESET_BYTE;
			if (reg_rd) begin
				case (reg_addr)
				`TMR16_CTRL_A: reg_rdata <= ctrl_a_r;
				`TMR16_CTRL_B:
					reg_rdata <= {capture_noise_filter_en, capture_edge_sel,
						1'b0, wave_hi_r, clock_source_sel};
				`TMR16_CTRL_C: reg_rdata <= `TMR16_RESET_BYTE;
				`TMR16_CNT_L: reg_rdata <= counter_register[7:0];
				`TMR16_CMPA_L: reg_rdata <= cmpa_buf_r[7:0];
				`TMR16_CMPB_L: reg_rdata <= cmpb_buf_r[7:0];
				`TMR16_CAPT_L: reg_rdata <= capture_register[7:0];
				`TMR16_CNT_H, `TMR16_CMPA_H, `TMR16_CMPB_H, `TMR16_CAPT_H:
					reg_rdata <= high_latch_r;
				`TMR16_IRQ_MASK:
					reg_rdata <= {2'h0, capture_irq_en, 2'h0, compare_b_irq_en,
						compare_a_irq_en, overflow_irq_en};
				`TMR16_IRQ_FLAGS:
					reg_rdata <= {2'h0, capture_flag, 2'h0, compare_b_flag,
						compare_a_flag, overflow_flag};
				default: reg_rdata <= `TMR16_RESET_BYTE;
				endcase
			end
		end
	end

	// Requests and waveform outputs
	always @(posedge clk) begin
		if (srst) begin
			capture_irq <= 1'b0;
			compare_a_irq <= 1'b0;
			compare_b_irq <= 1'b0;
			overflow_irq <= 1'b0;
			compare_output_a_pin <= 1'b0;
			compare_output_b_pin <= 1'b0;
			compare_output_a_oe <= 1'b0;
			compare_output_b_oe <= 1'b0;
		end else begin
			capture_irq <= capture_flag & capture_irq_en & global_irq_en;
			compare_a_irq <= compare_a_flag & compare_a_irq_en &
				global_irq_en;
			compare_b_irq <= compare_b_flag & compare_b_irq_en &
				global_irq_en;
			overflow_irq <= overflow_flag & overflow_irq_en & global_irq_en;
			// A forced strobe acts like a match here only, never on flags
			compare_output_a_pin <= wave_next(compare_output_a_pin, act_a,
				match_a | force_a, tick & at_top, toggle_a_ok, fast_mode,
				phase_mode, count_up_r);
			compare_output_b_pin <= wave_next(compare_output_b_pin, act_b,
				match_b | force_b, tick & at_top, 1'b0, fast_mode,
				phase_mode, count_up_r);
			compare_output_a_oe <= act_a[1] | (act_a[0] &
				(nonpwm_mode | toggle_a_ok));
			compare_output_b_oe <= act_b[1] | (act_b[0] & nonpwm_mode);
		end
	end
endmodule

// ==== core/tmr16_regs.vh ====
`ifndef TMR16_REGS_VH
`define TMR16_REGS_VH

// Register byte offsets
`define TMR16_CTRL_A 8'h00
`define TMR16_CTRL_B 8'h01
`define TMR16_CTRL_C 8'h02
`define TMR16_CNT_L 8'h04
`define TMR16_CNT_H 8'h05
`define TMR16_CMPA_L 8'h06
`define TMR16_CMPA_H 8'h07
`define TMR16_CMPB_L 8'h08
`define TMR16_CMPB_H 8'h09
`define TMR16_CAPT_L 8'h0a
`define TMR16_CAPT_H 8'h0b
`define TMR16_IRQ_MASK 8'h0c
`define TMR16_IRQ_FLAGS 8'h0d

// Control A fields
`define TMR16_ACT_A_HI 7
`define TMR16_ACT_A_LO 6
`define TMR16_ACT_B_HI 5
`define TMR16_ACT_B_LO 4
`define TMR16_CAPT_SRC_BIT 2
`define TMR16_WAVE_LO_HI 1
`define TMR16_WAVE_LO_LO 0

// Control B fields
`define TMR16_NOISE_BIT 7
`define TMR16_EDGE_BIT 6
`define TMR16_WAVE_HI_HI 4
`define TMR16_WAVE_HI_LO 3
`define TMR16_CLKSEL_HI 2
`define TMR16_CLKSEL_LO 0

// Control C fields
`define TMR16_FORCE_A_BIT 7
`define TMR16_FORCE_B_BIT 6

// Mask and flag fields
`define TMR16_CAPT_BIT 5
`define TMR16_CMPB_BIT 2
`define TMR16_CMPA_BIT 1
`define TMR16_OVF_BIT 0

// Clock select codes
`define TMR16_CS_STOP 3'h0
`define TMR16_CS_DIV1 3'h1
`define TMR16_CS_DIV8 3'h2
`define TMR16_CS_DIV64 3'h3
`define TMR16_CS_DIV256 3'h4
`define TMR16_CS_DIV1024 3'h5
`define TMR16_CS_EXT_FALL 3'h6
`define TMR16_CS_EXT_RISE 3'h7

// Fixed TOP values, filter depth and reset values
`define TMR16_MAX 16'hffff
`define TMR16_TOP8 16'h00ff
`define TMR16_TOP9 16'h01ff
`define TMR16_TOP10 16'h03ff
`define TMR16_FILTER_SAMPLES 4
`define TMR16_RESET_BYTE 8'h00
`define TMR16_RESET_WORD 16'h0000

`endif

// ==== core/tmr16_edge_filter.v ====
`timescale 1ns/10ps
`include "tmr16_regs.vh"

module tmr16_edge_filter #(
	parameter SAMPLES = `TMR16_FILTER_SAMPLES
) (
	clk,
	srst,
	filter_en,
	sample_in,
	level_out,
	rise_out,
	fall_out
);
	input wire clk;
	input wire srst;
	input wire filter_en;
	input wire sample_in;
	output reg level_out;
	output wire rise_out;
	output wire fall_out;

	// Only the last SAMPLES-1 samples are kept; the live pin is the newest
	reg [SAMPLES-2:0] hist_r;
	reg prev_r;
	wire all_one;
	wire all_zero;

	assign all_one = &{hist_r[SAMPLES-2:0], sample_in};
	assign all_zero = ~|{hist_r[SAMPLES-2:0], sample_in};
	assign rise_out = level_out & ~prev_r;
	assign fall_out = ~level_out & prev_r;

	// Idle level high so a pin held high at reset gives no edge
	always @(posedge clk) begin
		if (srst) begin
			hist_r <= {(SAMPLES-1){1'b1}};
			level_out <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			hist_r <= {hist_r[SAMPLES-3:0], sample_in};
			prev_r <= level_out;
			if (!filter_en)
				level_out <= sample_in;
			else if (all_one)
				level_out <= 1'b1;
			else if (all_zero)
				level_out <= 1'b0;
		end
	end
endmodule

// ==== sim/tmr16_pin_model.sv ====
`timescale 1ns/10ps
module tmr16_pin_model (
	input wire clk,
	output logic cap_pin,
	output logic cnt_pin
);
	// Capture pin idles high, matching the filter's reset level; count pin idles low
	initial begin
		cap_pin = 1'b1;
		cnt_pin = 1'b0;
	end
	// Levels held well past the edge detector latency
	task pulses(input int n);
		repeat (n) begin
			@(posedge clk);
			cnt_pin <= 1'b1;
			repeat (4) @(posedge clk);
			cnt_pin <= 1'b0;
			repeat (4) @(posedge clk);
		end
	endtask
	task cap(input logic v, input int hold);
		@(posedge clk);
		cap_pin <= v;
		repeat (hold) @(posedge clk);
	endtask
endmodule

// ==== sim/tmr16_core_properties.sv ====
`timescale 1ns/10ps
`include "tmr16_regs.vh"
module tmr16_core_properties (
	input wire clk,
	input wire srst,
	input wire [7:0] reg_addr,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire global_irq_en,
	input wire capture_irq,
	input wire compare_a_irq,
	input wire compare_b_irq,
	input wire overflow_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_force_read_zero: assert property ($past(reg_rd) &&
		$past(reg_addr) == `TMR16_CTRL_C |-> reg_rdata == 8'h00)
		else $error("force bits read nonzero");
	a_mask_unused_zero: assert property ($past(reg_rd) &&
		$past(reg_addr) == `TMR16_IRQ_MASK |-> (reg_rdata & 8'hd8) == 8'h00)
		else $error("unused mask bits read nonzero");
	a_flag_unused_zero: assert property ($past(reg_rd) &&
		$past(reg_addr) == `TMR16_IRQ_FLAGS |-> (reg_rdata & 8'hd8) == 8'h00)
		else $error("unused flag bits read nonzero");
	a_unmapped_read_zero: assert property ($past(reg_rd) &&
		($past(reg_addr) == 8'h03 || $past(reg_addr) > 8'h0d) |->
		reg_rdata == 8'h00)
		else $error("unmapped address read nonzero");
	a_cap_irq_gate: assert property (capture_irq |-> $past(global_irq_en))
		else $error("capture irq without global enable");
	a_cmpa_irq_gate: assert property (compare_a_irq |-> $past(global_irq_en))
		else $error("compare a irq without global enable");
	a_cmpb_irq_gate: assert property (compare_b_irq |-> $past(global_irq_en))
		else $error("compare b irq without global enable");
	a_ovf_irq_off: assert property (!global_irq_en |=> !overflow_irq)
		else $error("overflow irq without global enable");
endmodule
bind tmr16_core tmr16_core_properties i_props (.clk, .srst, .reg_addr,
	.reg_rd, .reg_rdata, .global_irq_en, .capture_irq, .compare_a_irq,
	.compare_b_irq, .overflow_irq);

// ==== sim/tb.sv ====
`timescale 1ns/10ps
`include "tmr16_regs.vh"
module tb;
	logic clk, srst, reg_wr, reg_rd, global_irq_en, acmp;
	wire ob, oea, oeb;
	logic [7:0] reg_addr, reg_wdata, d;
	logic [3:0] vector_ack;
	logic [15:0] w, v;
	wire [7:0] reg_rdata;
	wire capture_irq, oa, cap_pin, cnt_pin;
	int n_mismatch, n_checks, lo;
	int dv[5] = '{1, 8, 64, 256, 1024};
	logic [23:0] rows[5] = '{
		{`TMR16_CTRL_B, 8'hc0, 8'hc0},
		{`TMR16_CTRL_C, 8'hc0, 8'h00},
		{`TMR16_IRQ_MASK, 8'hff, 8'h27},
		{`TMR16_IRQ_FLAGS, 8'hff, 8'h00},
		{8'h03, 8'h5a, 8'h00}};
	tmr16_pin_model pins (.clk, .cap_pin, .cnt_pin);
	tmr16_core i_tmr16_core (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .capture_input_pin(cap_pin),
		.analog_comp_out(acmp), .external_count_pin(cnt_pin),
		.global_irq_en, .vector_ack, .capture_irq, .compare_a_irq(),
		.compare_b_irq(), .overflow_irq(), .compare_output_a_pin(oa),
		.compare_output_a_oe(oea), .compare_output_b_pin(ob),
		.compare_output_b_oe(oeb));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= x;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [7:0] a);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// High byte first: the low byte commits the pair
	task wr16(input logic [7:0] a, input logic [15:0] x);
		wr(a + 8'h01, x[15:8]);
		wr(a, x[7:0]);
	endtask
	task rd16(input logic [7:0] a);
		rd(a);
		w[7:0] = d;
		rd(a + 8'h01);
		w[15:8] = d;
	endtask
	task run(input logic [7:0] cb, input int n);
		wr(`TMR16_CTRL_B, cb);
		repeat (n) @(posedge clk);
		wr(`TMR16_CTRL_B, 8'h00);
	endtask
	task flags(input logic [7:0] m, input logic [7:0] e);
		rd(`TMR16_IRQ_FLAGS);
		chk({8'h00, d & m}, {8'h00, e});
	endtask
	task irq_is(input logic e);
		repeat (3) @(posedge clk);
		#1 chk({15'h0, capture_irq}, {15'h0, e});
	endtask
	task end_sim;
		if (n_mismatch == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		end_sim;
	end
	initial begin
		srst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		global_irq_en = 1'b0;
		acmp = 1'b0;
		vector_ack = 4'h0;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		for (int a = 0; a < 14; a++) begin
			rd(8'(a));
			chk({8'h00, d}, 16'h0000);
		end
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rd(rows[i][23:16]);
			chk({8'h00, d}, {8'h00, rows[i][7:0]});
		end
		wr16(`TMR16_CAPT_L, 16'hbeef);
		rd16(`TMR16_CAPT_L);
		chk(w, 16'hbeef);
		// One latch for all: high byte staged for B lands in A
		wr(`TMR16_CMPB_H, 8'h77);
		wr(`TMR16_CMPA_L, 8'h01);
		rd16(`TMR16_CMPA_L);
		chk(w, 16'h7701);
		foreach (dv[i]) begin
			wr16(`TMR16_CNT_L, 16'h0000);
			run(8'(i + 1), 2048);
			rd16(`TMR16_CNT_L);
			lo = 2048 / dv[i];
			chk({15'h0, w >= lo && w <= lo + 4}, 16'h0001);
		end
		v = w;
		repeat (20) @(posedge clk);
		rd16(`TMR16_CNT_L);
		chk(w, v);
		for (int e = 6; e < 8; e++) begin
			wr16(`TMR16_CNT_L, 16'h0000);
			wr(`TMR16_CTRL_B, 8'(e));
			pins.pulses(5);
			wr(`TMR16_CTRL_B, 8'h00);
			rd16(`TMR16_CNT_L);
			chk(w, 16'h0005);
		end
		wr(`TMR16_IRQ_FLAGS, 8'hff);
		wr16(`TMR16_CNT_L, 16'h0abc);
		wr(`TMR16_CTRL_B, 8'h40);
		pins.cap(1'b0, 8);
		flags(8'h20, 8'h00);
		pins.cap(1'b1, 8);
		flags(8'h20, 8'h20);
		rd16(`TMR16_CAPT_L);
		chk(w, 16'h0abc);
		wr(`TMR16_IRQ_FLAGS, 8'h20);
		flags(8'h27, 8'h00);
		wr16(`TMR16_CNT_L, 16'h1111);
		wr(`TMR16_CTRL_B, 8'h00);
		pins.cap(1'b0, 8);
		rd16(`TMR16_CAPT_L);
		chk(w, 16'h1111);
		wr(`TMR16_IRQ_FLAGS, 8'hff);
		// Three high samples must not pass the filter
		wr(`TMR16_CTRL_B, 8'hc0);
		pins.cap(1'b1, 2);
		pins.cap(1'b0, 8);
		flags(8'h20, 8'h00);
		pins.cap(1'b1, 10);
		flags(8'h20, 8'h20);
		irq_is(1'b0);
		@(posedge clk);
		global_irq_en <= 1'b1;
		irq_is(1'b1);
		@(posedge clk);
		vector_ack <= 4'h8;
		@(posedge clk);
		vector_ack <= 4'h0;
		irq_is(1'b0);
		wr(`TMR16_CTRL_B, 8'h58);
		pins.cap(1'b0, 8);
		pins.cap(1'b1, 8);
		flags(8'h20, 8'h00);
		wr16(`TMR16_CAPT_L, 16'h0010);
		wr16(`TMR16_CNT_L, 16'h0000);
		run(8'h59, 40);
		flags(8'h20, 8'h20);
		wr(`TMR16_IRQ_FLAGS, 8'hff);
		wr16(`TMR16_CMPA_L, 16'h0040);
		wr16(`TMR16_CMPB_L, 16'h0050);
		wr16(`TMR16_CNT_L, 16'h0000);
		run(8'h01, 120);
		flags(8'h07, 8'h06);
		wr(`TMR16_IRQ_FLAGS, 8'hff);
		wr16(`TMR16_CNT_L, 16'h0050);
		run(8'h01, 10);
		flags(8'h04, 8'h00);
		wr16(`TMR16_CNT_L, 16'hfffe);
		run(8'h01, 10);
		flags(8'h01, 8'h01);
		// Comparator as capture source, rising edge, counter stopped
		wr(`TMR16_CTRL_B, 8'h40);
		wr(`TMR16_IRQ_FLAGS, 8'hff);
		wr(`TMR16_CTRL_A, 8'h04);
		@(posedge clk);
		acmp <= 1'b1;
		repeat (4) @(posedge clk);
		flags(8'h20, 8'h20);
		wr(`TMR16_IRQ_FLAGS, 8'hff);
		wr(`TMR16_CTRL_A, 8'h70);
		wr(`TMR16_CTRL_C, 8'hc0);
		repeat (2) @(posedge clk);
		#1 chk({15'h0, oa}, 16'h0001);
		chk({15'h0, ob}, 16'h0001);
		chk({14'h0, oea, oeb}, 16'h0003);
		flags(8'h27, 8'h00);
		end_sim;
	end
endmodule
